// ===== itr_cfg.svh
// Constants for the two-wire register port: addresses, field layout,
// reset values and bit timing. Included by both ends, not by the link.
`ifndef ITR_CFG_SVH
`define ITR_CFG_SVH

// Target address: upper five bits fixed, low two from the strap
`define ITR_ADDR_BASE 5'h12
`define ITR_GC_ADDR 8'h00
`define ITR_GC_RESET_CMD 8'h06

// Register select codes
`define ITR_SEL_CONV 2'h0
`define ITR_SEL_CFG 2'h1
`define ITR_SEL_LO 2'h2
`define ITR_SEL_HI 2'h3

// Reset values
`define ITR_CONV_RST 16'h0000
`define ITR_CFG_RST 16'h8583
`define ITR_LO_RST 16'h8000
`define ITR_HI_RST 16'h7fff
`define ITR_SEL_RST 2'h0
`define ITR_TADDR_RST 7'h48

// Clipping codes
`define ITR_POS_FS 16'h7fff
`define ITR_NEG_FS 16'h8000

// Controller bit timing: four quarter phases per bit
`define ITR_CLK_MHZ 200
`define ITR_SCL_PERIOD_NS 2500
`define ITR_QTR_CYC ((`ITR_SCL_PERIOD_NS * `ITR_CLK_MHZ) / 4000)

// Controller Wishbone map (byte addresses)
`define ITR_WB_CMD 8'h00
`define ITR_WB_WDATA 8'h04
`define ITR_WB_STAT 8'h08
`define ITR_WB_RDATA 8'h0c

// Command register fields
`define ITR_CMD_OP_LSB 0
`define ITR_CMD_GO_BIT 2
`define ITR_CMD_ADDR_LSB 3
`define ITR_CMD_PTR_LSB 10

`endif

// ===== itr_pkg.sv
// Types shared by both ends of the two-wire register port.
// Assumes itr_cfg.svh for all numeric constants.
package itr_pkg;

   typedef enum logic [2:0] {
      TS_IDLE = 3'h0,
      TS_RX = 3'h1,
      TS_ACK = 3'h2,
      TS_TX = 3'h3,
      TS_MACK = 3'h4
   } itr_tstate_t;

   typedef enum logic [2:0] {
      BK_ADDR = 3'h0,
      BK_PTR = 3'h1,
      BK_DHI = 3'h2,
      BK_DLO = 3'h3,
      BK_GC = 3'h4,
      BK_NONE = 3'h5
   } itr_byte_t;

   typedef enum logic [1:0] {
      OP_PTR = 2'h0,
      OP_WR = 2'h1,
      OP_RD = 2'h2,
      OP_GC = 2'h3
   } itr_op_t;

   typedef enum logic [1:0] {
      CS_IDLE = 2'h0,
      CS_START = 2'h1,
      CS_BIT = 2'h2,
      CS_STOP = 2'h3
   } itr_cstate_t;

   typedef struct packed {
      itr_tstate_t st;
      itr_byte_t kind;
      logic scl_s1, scl_s2, scl_s3;
      logic sda_s1, sda_s2, sda_s3;
      logic [1:0] strap_s1, strap_s2;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic rw;
      logic [7:0] hold;
      logic [1:0] sel;
      logic [15:0] cfg, lo, hi, conv;
      logic pd, gc_pulse;
      logic sda_o, sda_oe_b;
   } itr_tgt_st_t;

   typedef struct packed {
      itr_cstate_t cs;
      itr_op_t op;
      logic [6:0] taddr;
      logic [1:0] ptr;
      logic [15:0] wdata, rdata;
      logic busy, nack;
      logic [15:0] qcnt;
      logic [1:0] ph;
      logic [3:0] bc;
      logic [1:0] bi;
      logic [7:0] sh;
      logic sda_s1, sda_s2;
      logic scl_o, scl_oe_b, sda_o, sda_oe_b;
      logic ack;
      logic [31:0] dat;
   } itr_ctl_st_t;

endpackage

// ===== itr_link_if.sv
// Open-drain two-wire link between controller and target.
// Both lines are pulled high unless an enabled driver pulls them low.
`timescale 1ns/1ps
interface itr_link_if;
   logic ctl_scl_o;
   logic ctl_scl_oe_b;
   logic ctl_sda_o;
   logic ctl_sda_oe_b;
   logic tgt_sda_o;
   logic tgt_sda_oe_b;
   logic scl;
   logic sda;

   assign scl = ctl_scl_oe_b | ctl_scl_o;
   assign sda = (ctl_sda_oe_b | ctl_sda_o) & (tgt_sda_oe_b | tgt_sda_o);

   modport controller(output ctl_scl_o, ctl_scl_oe_b, ctl_sda_o, ctl_sda_oe_b, input scl, sda);
   modport target(output tgt_sda_o, tgt_sda_oe_b, input scl, sda);
endinterface

// ===== itr_target.sv
// Target end of the two-wire register port: pointer, four 16-bit
// registers, clipped conversion result. Assumes core_clk_i far faster
// than the link clock; both link lines are oversampled.
// Function
// - Address plus write bit enters receive mode
// - Controller sends pointer right after address
// - Acknowledge the pointer byte
// - Next two bytes written to selected register
// - Upper byte first, lower byte second
// - Read returns upper byte of selected register
// - Controller acks upper, then lower is sent
// - Stop sending on nack, start or stop
// - After pointer, controller stops or restarts
// - Pointer-only write updates only the select
// - New register read needs prior pointer write
// - Select kept across transfers until rewritten
// - Data writes always carry pointer first
// - Select codes: result, config, low, high
// - Never drive the clock line
// - Results are 16-bit two's complement
// - Results clip at 7fff and 8000
// - Result register read-only, holds latest
// - Result register zero after power-up
// - Strap picks one of four addresses
// - General call 06 resets and powers down
`timescale 1ns/1ps
`include "itr_cfg.svh"
module itr_target #(
   parameter int RAW_W = 18
) (
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   itr_link_if.target link,
   input wire logic id_strap_bit_low_i,
   input wire logic id_strap_bit_high_i,
   input wire logic conv_valid_i,
   input wire logic signed [RAW_W-1:0] conv_raw_i,
   output logic [1:0] reg_sel_o,
   output logic [15:0] config_o,
   output logic [15:0] lower_limit_reg_o,
   output logic [15:0] upper_limit_reg_o,
   output logic [15:0] conv_result_o,
   output logic powerdown_o,
   output logic gc_reset_o
);

   localparam logic signed [RAW_W-1:0] POS_LIM = RAW_W'($signed(`ITR_POS_FS));
   localparam logic signed [RAW_W-1:0] NEG_LIM = RAW_W'($signed(`ITR_NEG_FS));

   itr_pkg::itr_tgt_st_t s_r;
   itr_pkg::itr_tgt_st_t s_nxt;

   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic [6:0] own_addr;
   logic [15:0] rd_word;

   // Wide raw value clipped to the 16-bit code range
   function automatic logic [15:0] clip16(input logic signed [RAW_W-1:0] v);
      logic [15:0] r;
      r = v[15:0];
      if (v > POS_LIM) begin
         r = `ITR_POS_FS;
      end else if (v < NEG_LIM) begin
         r = `ITR_NEG_FS;
      end
      return r;
   endfunction

   function automatic logic [15:0] sel_word(input logic [1:0] sel, input itr_pkg::itr_tgt_st_t st);
      logic [15:0] r;
      case (sel)
         `ITR_SEL_CONV: r = st.conv;
         `ITR_SEL_CFG: r = st.cfg;
         `ITR_SEL_LO: r = st.lo;
         default: r = st.hi;
      endcase
      return r;
   endfunction

   // Edges only from the second and third stages, never the first
   assign scl_rise = s_r.scl_s2 & ~s_r.scl_s3;
   assign scl_fall = ~s_r.scl_s2 & s_r.scl_s3;
   assign start_det = s_r.scl_s2 & s_r.scl_s3 & ~s_r.sda_s2 & s_r.sda_s3;
   assign stop_det = s_r.scl_s2 & s_r.scl_s3 & s_r.sda_s2 & ~s_r.sda_s3;
   assign own_addr = {`ITR_ADDR_BASE, s_r.strap_s2[1], s_r.strap_s2[0]};
   assign rd_word = sel_word(s_r.sel, s_r);

   always_comb begin
      s_nxt = s_r;
      s_nxt.scl_s1 = link.scl;
      s_nxt.scl_s2 = s_r.scl_s1;
      s_nxt.scl_s3 = s_r.scl_s2;
      s_nxt.sda_s1 = link.sda;
      s_nxt.sda_s2 = s_r.sda_s1;
      s_nxt.sda_s3 = s_r.sda_s2;
      s_nxt.strap_s1 = {id_strap_bit_high_i, id_strap_bit_low_i};
      s_nxt.strap_s2 = s_r.strap_s1;
      s_nxt.gc_pulse = 1'b0;
      if (conv_valid_i) begin
         s_nxt.conv = clip16(conv_raw_i);
      end
      if (start_det) begin
         // A start or repeated start aborts anything in flight
         s_nxt.st = itr_pkg::TS_RX;
         s_nxt.kind = itr_pkg::BK_ADDR;
         s_nxt.cnt = 4'h0;
         s_nxt.sda_oe_b = 1'b1;
      end else if (stop_det) begin
         s_nxt.st = itr_pkg::TS_IDLE;
         s_nxt.sda_oe_b = 1'b1;
      end else begin
         case (s_r.st)
            itr_pkg::TS_RX: begin
               if (scl_rise) begin
                  s_nxt.sh = {s_r.sh[6:0], s_r.sda_s2};
                  s_nxt.cnt = s_r.cnt + 4'h1;
               end else if (scl_fall && s_r.cnt == 4'h8) begin
                  s_nxt.cnt = 4'h0;
                  s_nxt.st = itr_pkg::TS_ACK;
                  s_nxt.sda_oe_b = 1'b0;
                  case (s_r.kind)
                     itr_pkg::BK_ADDR: begin
                        if (s_r.sh[7:1] == own_addr) begin
                           s_nxt.rw = s_r.sh[0];
                           s_nxt.kind = itr_pkg::BK_PTR;
                        end else if (s_r.sh == `ITR_GC_ADDR) begin
                           s_nxt.rw = 1'b0;
                           s_nxt.kind = itr_pkg::BK_GC;
                        end else begin
                           s_nxt.st = itr_pkg::TS_IDLE;
                           s_nxt.sda_oe_b = 1'b1;
                        end
                     end
                     itr_pkg::BK_PTR: begin
                        s_nxt.sel = s_r.sh[1:0];
                        s_nxt.kind = itr_pkg::BK_DHI;
                     end
                     itr_pkg::BK_DHI: begin
                        s_nxt.hold = s_r.sh;
                        s_nxt.kind = itr_pkg::BK_DLO;
                     end
                     itr_pkg::BK_DLO: begin
                        s_nxt.kind = itr_pkg::BK_NONE;
                        case (s_r.sel)
                           `ITR_SEL_CFG: begin
                              s_nxt.cfg = {s_r.hold, s_r.sh};
                              s_nxt.pd = 1'b0;
                           end
                           `ITR_SEL_LO: s_nxt.lo = {s_r.hold, s_r.sh};
                           `ITR_SEL_HI: s_nxt.hi = {s_r.hold, s_r.sh};
                           default: s_nxt.conv = s_nxt.conv;
                        endcase
                     end
                     itr_pkg::BK_GC: begin
                        s_nxt.kind = itr_pkg::BK_NONE;
                        if (s_r.sh == `ITR_GC_RESET_CMD) begin
                           s_nxt.cfg = `ITR_CFG_RST;
                           s_nxt.lo = `ITR_LO_RST;
                           s_nxt.hi = `ITR_HI_RST;
                           s_nxt.conv = `ITR_CONV_RST;
                           s_nxt.sel = `ITR_SEL_RST;
                           s_nxt.pd = 1'b1;
                           s_nxt.gc_pulse = 1'b1;
                        end else begin
                           s_nxt.st = itr_pkg::TS_IDLE;
                           s_nxt.sda_oe_b = 1'b1;
                        end
                     end
                     default: begin
                        // Bytes past the second data byte are refused
                        s_nxt.st = itr_pkg::TS_IDLE;
                        s_nxt.sda_oe_b = 1'b1;
                     end
                  endcase
               end
            end
            itr_pkg::TS_ACK: begin
               if (scl_fall) begin
                  if (s_r.rw) begin
                     s_nxt.st = itr_pkg::TS_TX;
                     s_nxt.kind = itr_pkg::BK_DHI;
                     s_nxt.sh = rd_word[15:8];
                     s_nxt.sda_oe_b = rd_word[15];
                  end else begin
                     s_nxt.st = itr_pkg::TS_RX;
                     s_nxt.sda_oe_b = 1'b1;
                  end
               end
            end
            itr_pkg::TS_TX: begin
               // Open drain: a one is sent by releasing the line
               if (scl_fall) begin
                  if (s_r.cnt == 4'h7) begin
                     s_nxt.st = itr_pkg::TS_MACK;
                     s_nxt.cnt = 4'h0;
                     s_nxt.sda_oe_b = 1'b1;
                  end else begin
                     s_nxt.sh = {s_r.sh[6:0], 1'b0};
                     s_nxt.cnt = s_r.cnt + 4'h1;
                     s_nxt.sda_oe_b = s_r.sh[6];
                  end
               end
            end
            itr_pkg::TS_MACK: begin
               if (scl_rise && s_r.sda_s2) begin
                  s_nxt.st = itr_pkg::TS_IDLE;
               end else if (scl_fall) begin
                  if (s_r.kind == itr_pkg::BK_DHI) begin
                     s_nxt.st = itr_pkg::TS_TX;
                     s_nxt.kind = itr_pkg::BK_DLO;
                     s_nxt.sh = rd_word[7:0];
                     s_nxt.sda_oe_b = rd_word[7];
                  end else begin
                     s_nxt.st = itr_pkg::TS_IDLE;
                  end
               end
            end
            default: s_nxt.st = itr_pkg::TS_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         s_r <= '0;
         s_r.st <= itr_pkg::TS_IDLE;
         s_r.kind <= itr_pkg::BK_NONE;
         s_r.scl_s1 <= 1'b1;
         s_r.scl_s2 <= 1'b1;
         s_r.scl_s3 <= 1'b1;
         s_r.sda_s1 <= 1'b1;
         s_r.sda_s2 <= 1'b1;
         s_r.sda_s3 <= 1'b1;
         s_r.sel <= `ITR_SEL_RST;
         s_r.cfg <= `ITR_CFG_RST;
         s_r.lo <= `ITR_LO_RST;
         s_r.hi <= `ITR_HI_RST;
         s_r.conv <= `ITR_CONV_RST;
         s_r.sda_oe_b <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // No clock driver exists on this end at all
   assign link.tgt_sda_o = s_r.sda_o;
   assign link.tgt_sda_oe_b = s_r.sda_oe_b;
   assign reg_sel_o = s_r.sel;
   assign config_o = s_r.cfg;
   assign lower_limit_reg_o = s_r.lo;
   assign upper_limit_reg_o = s_r.hi;
   assign conv_result_o = s_r.conv;
   assign powerdown_o = s_r.pd;
   assign gc_reset_o = s_r.gc_pulse;

endmodule

// ===== itr_controller.sv
// Controller end: runs one whole transfer per command, ordered over a
// classic Wishbone slave. Makes the link clock by dividing core_clk_i.
`timescale 1ns/1ps
`include "itr_cfg.svh"
module itr_controller #(
   parameter int QTR_CYC = `ITR_QTR_CYC
) (
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   itr_link_if.controller link,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic busy_o
);

   itr_pkg::itr_ctl_st_t s_r;
   itr_pkg::itr_ctl_st_t s_nxt;

   logic tick;
   logic is_rx;
   logic [1:0] last_bi;
   logic [31:0] wmask;

   function automatic logic [7:0] tx_byte(input itr_pkg::itr_ctl_st_t st, input logic [1:0] bi);
      logic [7:0] r;
      case (bi)
         2'h0: r = (st.op == itr_pkg::OP_GC) ? `ITR_GC_ADDR : {st.taddr, st.op == itr_pkg::OP_RD};
         2'h1: r = (st.op == itr_pkg::OP_GC) ? `ITR_GC_RESET_CMD : {6'h00, st.ptr};
         2'h2: r = st.wdata[15:8];
         default: r = st.wdata[7:0];
      endcase
      return r;
   endfunction

   assign tick = (s_r.qcnt == 16'h0000);
   assign is_rx = (s_r.op == itr_pkg::OP_RD) && (s_r.bi != 2'h0);
   assign last_bi = (s_r.op == itr_pkg::OP_WR) ? 2'h3 : (s_r.op == itr_pkg::OP_RD) ? 2'h2 : 2'h1;
   assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

   always_comb begin
      s_nxt = s_r;
      s_nxt.sda_s1 = link.sda;
      s_nxt.sda_s2 = s_r.sda_s1;
      s_nxt.ack = 1'b0;
      if (s_r.cs != itr_pkg::CS_IDLE) begin
         s_nxt.qcnt = tick ? 16'(QTR_CYC - 1) : s_r.qcnt - 16'h0001;
      end
      if (wb_cyc_i && wb_stb_i && !s_r.ack) begin
         s_nxt.ack = 1'b1;
         case (wb_adr_i)
            `ITR_WB_CMD: s_nxt.dat = {20'h00000, s_r.ptr, s_r.taddr, 1'b0, s_r.op};
            `ITR_WB_WDATA: s_nxt.dat = {16'h0000, s_r.wdata};
            `ITR_WB_STAT: s_nxt.dat = {30'h0, s_r.nack, s_r.busy};
            `ITR_WB_RDATA: s_nxt.dat = {16'h0000, s_r.rdata};
            default: s_nxt.dat = 32'h00000000;
         endcase
         // Orders written while busy are dropped, not queued
         if (wb_we_i && !s_r.busy) begin
            if (wb_adr_i == `ITR_WB_WDATA) begin
               s_nxt.wdata = (s_r.wdata & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
            end else if (wb_adr_i == `ITR_WB_CMD && wb_sel_i[0] && wb_sel_i[1]) begin
               s_nxt.op = itr_pkg::itr_op_t'(wb_dat_i[`ITR_CMD_OP_LSB +: 2]);
               s_nxt.taddr = wb_dat_i[`ITR_CMD_ADDR_LSB +: 7];
               s_nxt.ptr = wb_dat_i[`ITR_CMD_PTR_LSB +: 2];
               if (wb_dat_i[`ITR_CMD_GO_BIT]) begin
                  s_nxt.busy = 1'b1;
                  s_nxt.nack = 1'b0;
                  s_nxt.cs = itr_pkg::CS_START;
                  s_nxt.ph = 2'h0;
                  s_nxt.bi = 2'h0;
                  s_nxt.qcnt = 16'(QTR_CYC - 1);
               end
            end
         end
      end
      if (tick && s_r.cs != itr_pkg::CS_IDLE) begin
         s_nxt.ph = s_r.ph + 2'h1;
         case (s_r.cs)
            itr_pkg::CS_START: begin
               if (s_r.ph == 2'h1) begin
                  s_nxt.sda_oe_b = 1'b0;
               end else if (s_r.ph == 2'h2) begin
                  s_nxt.scl_oe_b = 1'b0;
               end else if (s_r.ph == 2'h3) begin
                  s_nxt.cs = itr_pkg::CS_BIT;
                  s_nxt.bc = 4'h0;
                  s_nxt.sh = tx_byte(s_r, 2'h0);
               end
            end
            itr_pkg::CS_BIT: begin
               case (s_r.ph)
                  2'h0: begin
                     if (s_r.bc == 4'h8) begin
                        s_nxt.sda_oe_b = is_rx ? 1'b0 : 1'b1;
                     end else begin
                        s_nxt.sda_oe_b = is_rx ? 1'b1 : s_r.sh[7];
                     end
                  end
                  2'h1: s_nxt.scl_oe_b = 1'b1;
                  2'h2: begin
                     if (s_r.bc != 4'h8 && is_rx) begin
                        s_nxt.sh = {s_r.sh[6:0], s_r.sda_s2};
                     end else if (s_r.bc == 4'h8 && !is_rx && s_r.sda_s2) begin
                        s_nxt.nack = 1'b1;
                     end
                  end
                  default: begin
                     s_nxt.scl_oe_b = 1'b0;
                     if (s_r.bc == 4'h8) begin
                        if (is_rx && s_r.bi == 2'h1) begin
                           s_nxt.rdata[15:8] = s_r.sh;
                        end else if (is_rx) begin
                           s_nxt.rdata[7:0] = s_r.sh;
                        end
                        if (s_nxt.nack || s_r.bi == last_bi) begin
                           s_nxt.cs = itr_pkg::CS_STOP;
                        end else begin
                           s_nxt.bi = s_r.bi + 2'h1;
                           s_nxt.bc = 4'h0;
                           s_nxt.sh = tx_byte(s_r, s_r.bi + 2'h1);
                        end
                     end else begin
                        s_nxt.bc = s_r.bc + 4'h1;
                        if (!is_rx) begin
                           s_nxt.sh = {s_r.sh[6:0], 1'b0};
                        end
                     end
                  end
               endcase
            end
            itr_pkg::CS_STOP: begin
               if (s_r.ph == 2'h0) begin
                  s_nxt.sda_oe_b = 1'b0;
               end else if (s_r.ph == 2'h1) begin
                  s_nxt.scl_oe_b = 1'b1;
               end else if (s_r.ph == 2'h2) begin
                  s_nxt.sda_oe_b = 1'b1;
               end else begin
                  s_nxt.cs = itr_pkg::CS_IDLE;
                  s_nxt.busy = 1'b0;
               end
            end
            default: s_nxt.cs = itr_pkg::CS_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         s_r <= '0;
         s_r.cs <= itr_pkg::CS_IDLE;
         s_r.op <= itr_pkg::OP_PTR;
         s_r.taddr <= `ITR_TADDR_RST;
         s_r.sda_s1 <= 1'b1;
         s_r.sda_s2 <= 1'b1;
         s_r.scl_oe_b <= 1'b1;
         s_r.sda_oe_b <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign link.ctl_scl_o = s_r.scl_o;
   assign link.ctl_scl_oe_b = s_r.scl_oe_b;
   assign link.ctl_sda_o = s_r.sda_o;
   assign link.ctl_sda_oe_b = s_r.sda_oe_b;
   assign wb_dat_o = s_r.dat;
   assign wb_ack_o = s_r.ack;
   assign busy_o = s_r.busy;

endmodule

// ===== itr_sva.sv
// Checker of the open-drain link between the two ends.
// Assumes QTR_CYC of at least 8, so every clock level lasts at least 8 cycles.
`timescale 1ns/1ps
module itr_sva (
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic ctl_scl_o,
   input wire logic ctl_scl_oe_b,
   input wire logic ctl_sda_o,
   input wire logic ctl_sda_oe_b,
   input wire logic tgt_sda_o,
   input wire logic tgt_sda_oe_b,
   input wire logic scl,
   input wire logic sda
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i);
   a_rst_lines_free: assert property ($rose(rst_b_i) |-> ctl_scl_oe_b && ctl_sda_oe_b && tgt_sda_oe_b)
      else $error("line driven out of reset");
   a_open_drain_only: assert property (!ctl_scl_o && !ctl_sda_o && !tgt_sda_o)
      else $error("line driven high");
   a_clk_ctl_only: assert property (!scl |-> !ctl_scl_oe_b)
      else $error("clock low without controller");
   a_tgt_low_phase: assert property ($fell(tgt_sda_oe_b) |-> !scl && !$past(scl))
      else $error("target drives data in clock high");
   a_start_hold: assert property (scl && $fell(sda) |-> scl [*4])
      else $error("start too short");
   a_stop_idle: assert property (scl && $rose(sda) |-> sda [*4])
      else $error("stop too short");
   a_scl_high_min: assert property ($rose(scl) |-> scl [*8])
      else $error("clock high too short");
   a_scl_low_min: assert property ($fell(scl) |-> !scl [*8])
      else $error("clock low too short");
   a_tgt_data_stable: assert property (scl && $past(scl) |-> $stable(tgt_sda_oe_b))
      else $error("target data changed while clock high");
   c_start: cover property (scl && $fell(sda));
   c_tgt_ack: cover property ($fell(tgt_sda_oe_b));
   c_stop: cover property (scl && $rose(sda));
endmodule

// ===== tb.sv
// Bench: controller and target joined by the link, driven over Wishbone.
// Assumes the Wishbone map and command layout of itr_cfg.svh.
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
   logic core_clk_i = 1'h0;
   logic rst_b_i = 1'h0;
   logic cyc = 1'h0;
   logic stb = 1'h0;
   logic we = 1'h0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [1:0] strap = 2'h0;
   logic cv = 1'h0;
   logic signed [17:0] raw = 18'h0;
   logic [31:0] rdat, st, rd;
   logic ack, pd, bsy, gcr;
   logic [1:0] sel;
   logic [15:0] lo, hi, conv, cfg;
   logic [3:0] be = 4'hf;
   logic [3:0] wsel = 4'hf;
   int n_gc = 0;
   int err_count = 0;
   int n_tests = 0;
   int i;
   // Raw codes beyond 16-bit range must clip
   logic [17:0] rw [6] = '{18'h1ffff, 18'h20000, 18'h3ffff, 18'h08000, 18'h37fff, 18'h01234};
   logic [15:0] ce [6] = '{16'h7fff, 16'h8000, 16'hffff, 16'h7fff, 16'h8000, 16'h1234};
   itr_link_if lnk ();
   itr_controller #(.QTR_CYC(8)) i_itr_controller (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
      .link(lnk.controller), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(wsel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .busy_o(bsy));
   itr_target i_itr_target (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .link(lnk.target),
      .id_strap_bit_low_i(strap[0]), .id_strap_bit_high_i(strap[1]), .conv_valid_i(cv),
      .conv_raw_i(raw), .reg_sel_o(sel), .config_o(cfg), .lower_limit_reg_o(lo),
      .upper_limit_reg_o(hi), .conv_result_o(conv), .powerdown_o(pd), .gc_reset_o(gcr));
   itr_sva i_itr_sva (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .ctl_scl_o(lnk.ctl_scl_o),
      .ctl_scl_oe_b(lnk.ctl_scl_oe_b), .ctl_sda_o(lnk.ctl_sda_o), .ctl_sda_oe_b(lnk.ctl_sda_oe_b),
      .tgt_sda_o(lnk.tgt_sda_o), .tgt_sda_oe_b(lnk.tgt_sda_oe_b), .scl(lnk.scl), .sda(lnk.sda));
   initial forever #2.5 core_clk_i = ~core_clk_i;
   // Reset pulses counted so a missing or doubled pulse shows
   always @(posedge core_clk_i) begin
      if (gcr === 1'h1) begin
         n_gc++;
      end
   end
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge core_clk_i);
      cyc <= 1'h1;
      stb <= 1'h1;
      we <= w;
      adr <= a;
      wdat <= d;
      wsel <= be;
      do begin
         @(posedge core_clk_i);
         n++;
      end while (ack !== 1'h1 && n < 50);
      q = rdat;
      cyc <= 1'h0;
      stb <= 1'h0;
      if (n >= 50) begin
         err_count++;
         final_report();
      end
   endtask
   // One whole link transfer; leaves status in st, read data in rd
   task automatic xf(input logic [1:0] op, input logic [6:0] a, input logic [1:0] s, input logic [15:0] d);
      int n;
      n = 0;
      wb(1'h1, 8'h04, {16'h0, d}, st);
      wb(1'h1, 8'h00, {20'h0, s, a, 1'h1, op}, st);
      `CHK(bsy, 1'h1)
      do begin
         wb(1'h0, 8'h08, 32'h0, st);
         n++;
      end while (st[0] !== 1'h0 && n < 2000);
      if (n >= 2000) begin
         err_count++;
         final_report();
      end
      wb(1'h0, 8'h0c, 32'h0, rd);
   endtask
   initial begin
      repeat (12) @(posedge core_clk_i);
      rst_b_i <= 1'h1;
      repeat (3) @(posedge core_clk_i);
      `CHK(sel, 2'h0)
      `CHK(conv, 16'h0)
      xf(2'h2, 7'h48, 2'h0, 16'h0);
      `CHK(rd[15:0], 16'h0)
      wb(1'h0, 8'h10, 32'h0, st);
      `CHK(st, 32'h0)
      // Byte enables: partial data write kept, half-enabled order dropped
      be = 4'h1;
      wb(1'h1, 8'h04, 32'h0000ffff, st);
      wb(1'h1, 8'h00, 32'h00000246, st);
      wb(1'h0, 8'h04, 32'h0, rd);
      `CHK(rd, 32'h000000ff)
      wb(1'h0, 8'h08, 32'h0, st);
      `CHK(st, 32'h0)
      be = 4'hf;
      $display("reset test done");
      for (i = 0; i < 6; i++) begin
         @(posedge core_clk_i);
         cv <= 1'h1;
         raw <= rw[i];
         @(posedge core_clk_i);
         cv <= 1'h0;
         repeat (2) @(posedge core_clk_i);
         `CHK(conv, ce[i])
      end
      $display("clip test done");
      for (i = 0; i < 4; i++) begin
         xf(2'h1, 7'h48, i[1:0], 16'ha5c0 + i[15:0]);
         `CHK(st[1], 1'h0)
         xf(2'h2, 7'h48, 2'h0, 16'h0);
         `CHK(sel, i[1:0])
         `CHK(rd[15:0], (i == 0) ? 16'h1234 : 16'ha5c0 + i[15:0])
      end
      `CHK(hi, 16'ha5c3)
      xf(2'h0, 7'h48, 2'h2, 16'h0);
      `CHK(sel, 2'h2)
      `CHK(lo, 16'ha5c2)
      repeat (2) begin
         xf(2'h2, 7'h48, 2'h0, 16'h0);
         `CHK(rd[15:0], 16'ha5c2)
      end
      $display("register test done");
      for (i = 0; i < 4; i++) begin
         strap <= i[1:0];
         xf(2'h0, {5'h12, i[1:0]}, i[1:0], 16'h0);
         `CHK(st[1], 1'h0)
         `CHK(sel, i[1:0])
         xf(2'h0, {5'h12, i[1:0] + 2'h1}, 2'h0, 16'h0);
         `CHK(st[1], 1'h1)
      end
      $display("address test done");
      xf(2'h3, 7'h00, 2'h0, 16'h0);
      `CHK(pd, 1'h1)
      `CHK(sel, 2'h0)
      `CHK(conv, 16'h0)
      `CHK(cfg, 16'h8583)
      `CHK(n_gc, 1)
      $display("general call test done");
      final_report();
   end
endmodule
